// ===== rtl/txdcw_top.v
// What this block does
// RQ1: Completion flag set: raise transmit interrupt status once that frame is sent.
// RQ2: Completion flag counts only on last-segment or setup-frame descriptors.
// RQ3: Last-segment bit ends frame assembly after this descriptor's buffers.
// RQ4: First-segment bit starts a new frame with this descriptor's data.
// RQ5: Bits 28 and 22 form the two-bit filter type used by setup frames.
// RQ6: Bit 27 marks a setup frame loading filter tables, not transmitted.
// RQ7: CRC-disable bit 26 suppresses CRC unless automatic padding applies.
// RQ8: CRC-disable bit is taken only from first-segment descriptors.
// RQ9: End-of-ring bit 25: next descriptor comes from the list base address.
// RQ10: Chained bit 24: second address word is the next descriptor pointer.
// RQ11: End-of-ring wins over chained when both are set.
// RQ12: Pad-disable bit 23 set: frames under 64 bytes are not padded.
// RQ13: Pad-disable clear and frame under 64 bytes: append pad then CRC.
// RQ14: Padded frames always get CRC, whatever the CRC-disable bit says.
// RQ15: Bits 21:11 are buffer two size; zero skips it.
// RQ16: Buffer two size ignored while the chained bit is set.
// RQ17: Bits 10:0 are buffer one size; zero skips it, uses buffer two.
// RQ18: Filter type 00 perfect, 01 hash plus one, 10 inverse, 11 hash only.
// RQ19: Software writes a complete control word before handing it over.
`include "txdcw_map.vh"
module txdcw_top (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire frame_sent,
    output reg frame_start_r,
    output reg frame_end_r,
    output reg [10:0] buf1_len_r,
    output reg [10:0] buf2_len_r,
    output reg crc_append_r,
    output reg [15:0] pad_len_r,
    output reg filter_load_r,
    output reg [1:0] filter_mode_r,
    output reg [31:0] next_desc_addr_r,
    output reg irq_r
);

// ------------------------------------------------------------
// Register storage
// ------------------------------------------------------------
reg [31:0] tx_desc_control_word_r;
reg [31:0] addr2_r;
reg [31:0] list_base_r;
reg [31:0] desc_addr_r;
reg [`TXDCW_NIRQ-1:0] irq_mask_r;
reg [15:0] frame_len_r;
reg frame_active_r;
reg crc_dis_r;
reg irq_pend_r;
reg setup_seen_r;
reg decode_go_r;
wire [`TXDCW_NIRQ-1:0] irq_stat;

// ------------------------------------------------------------
// AXI4-Lite write channel
// ------------------------------------------------------------
reg aw_have_r;
reg w_have_r;
reg [7:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
wire wr_fire;
wire [31:0] wmask;
wire wr_hit;

assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
assign wr_hit = (aw_addr_r == `TXDCW_OFF_CTRL) ||
                (aw_addr_r == `TXDCW_OFF_ADDR2) ||
                (aw_addr_r == `TXDCW_OFF_BASE) ||
                (aw_addr_r == `TXDCW_OFF_DADDR) ||
                (aw_addr_r == `TXDCW_OFF_IMASK);

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        aw_addr_r <= 8'h00;
        w_data_r <= 32'h00000000;
        w_strb_r <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `TXDCW_RESP_OKAY;
    end else begin
        s_axi_awready <= !aw_have_r && !s_axi_awready;
        s_axi_wready <= !w_have_r && !s_axi_wready;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `TXDCW_RESP_OKAY : `TXDCW_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// AXI4-Lite read channel
// ------------------------------------------------------------
reg rd_clr_r;
reg [31:0] rd_mux;
reg rd_hit;
wire [7:0] rd_addr;

assign rd_addr = {s_axi_araddr[7:2], 2'b00};

always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (rd_addr)
        `TXDCW_OFF_CTRL: rd_mux = tx_desc_control_word_r;
        `TXDCW_OFF_ADDR2: rd_mux = addr2_r;
        `TXDCW_OFF_BASE: rd_mux = list_base_r;
        `TXDCW_OFF_DADDR: rd_mux = desc_addr_r;
        `TXDCW_OFF_DSTAT: rd_mux = {26'h0000000, filter_mode_r,
                                    setup_seen_r, irq_pend_r,
                                    crc_dis_r, frame_active_r};
        `TXDCW_OFF_FLEN: rd_mux = {16'h0000, frame_len_r};
        `TXDCW_OFF_ISTAT: rd_mux = {29'h00000000, irq_stat};
        `TXDCW_OFF_IMASK: rd_mux = {29'h00000000, irq_mask_r};
        default: rd_hit = 1'b0;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `TXDCW_RESP_OKAY;
        rd_clr_r <= 1'b0;
    end else begin
        rd_clr_r <= 1'b0;
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `TXDCW_RESP_OKAY : `TXDCW_RESP_SLVERR;
            rd_clr_r <= (rd_addr == `TXDCW_OFF_ISTAT);
        end
        if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

// ------------------------------------------------------------
// Software registers
// ------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        tx_desc_control_word_r <= `TXDCW_RST_WORD;
        addr2_r <= 32'h00000000;
        list_base_r <= 32'h00000000;
        irq_mask_r <= 3'h0;
        decode_go_r <= 1'b0;
    end else begin
        decode_go_r <= 1'b0;
        if (wr_fire) begin
            case (aw_addr_r)
                `TXDCW_OFF_CTRL: begin
                    tx_desc_control_word_r <= (w_data_r & wmask) |
                        (tx_desc_control_word_r & ~wmask); // [RQ19]
                    decode_go_r <= 1'b1;
                end
                `TXDCW_OFF_ADDR2:
                    addr2_r <= (w_data_r & wmask) | (addr2_r & ~wmask);
                `TXDCW_OFF_BASE:
                    list_base_r <= (w_data_r & wmask) |
                        (list_base_r & ~wmask);
                `TXDCW_OFF_IMASK:
                    if (w_strb_r[0])
                        irq_mask_r <= w_data_r[`TXDCW_NIRQ-1:0];
                default: ;
            endcase
        end
    end
end

// ------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------
wire [31:0] cw;
wire completion_irq_flag;
wire last_segment_flag;
wire first_segment_flag;
wire filter_type_high;
wire filter_type_low;
wire setup_frame_flag;
wire crc_append_disable;
wire end_of_ring_flag;
wire chained_next_pointer_flag;
wire pad_disable_flag;
wire [10:0] second_buffer_byte_count;
wire [10:0] first_buffer_byte_count;
wire [10:0] buf2_eff;
wire [15:0] seg_len;
wire [15:0] total_len;
wire short_frame;
wire pad_on;
wire in_frame;
wire [31:0] next_addr;

assign cw = tx_desc_control_word_r;
assign completion_irq_flag = cw[`TXDCW_B_IRQ];
assign last_segment_flag = cw[`TXDCW_B_LAST];
assign first_segment_flag = cw[`TXDCW_B_FIRST];
assign filter_type_high = cw[`TXDCW_B_FTH];
assign filter_type_low = cw[`TXDCW_B_FTL];
assign setup_frame_flag = cw[`TXDCW_B_SETUP];
assign crc_append_disable = cw[`TXDCW_B_CRCDIS];
assign end_of_ring_flag = cw[`TXDCW_B_EOR];
assign chained_next_pointer_flag = cw[`TXDCW_B_CHAIN];
assign pad_disable_flag = cw[`TXDCW_B_PADDIS];
assign second_buffer_byte_count = cw[`TXDCW_B2_HI:`TXDCW_B2_LO];
assign first_buffer_byte_count = cw[`TXDCW_B1_HI:`TXDCW_B1_LO];

// No second buffer exists on a chained descriptor
assign buf2_eff = chained_next_pointer_flag ? 11'h000 :
                  second_buffer_byte_count; // [RQ15] [RQ16]
assign seg_len = {5'h00, first_buffer_byte_count} +
                 {5'h00, buf2_eff}; // [RQ17]
assign in_frame = first_segment_flag || frame_active_r;
assign total_len = first_segment_flag ? seg_len : frame_len_r + seg_len;
assign short_frame = total_len < `TXDCW_MIN_FRAME;
assign pad_on = short_frame && !pad_disable_flag; // [RQ12] [RQ13]

txdcw_nextaddr #(
    .AW(32)
) u_nextaddr (
    .eor(end_of_ring_flag),
    .chain(chained_next_pointer_flag),
    .list_base(list_base_r),
    .addr2(addr2_r),
    .cur(desc_addr_r),
    .stride(`TXDCW_DESC_BYTES),
    .nxt(next_addr)
);

// ------------------------------------------------------------
// Descriptor decode and frame assembly
// ------------------------------------------------------------
reg set_done;
reg set_setup;
reg set_err;

always @(posedge aclk) begin
    if (!aresetn) begin
        desc_addr_r <= 32'h00000000;
        next_desc_addr_r <= 32'h00000000;
        frame_len_r <= 16'h0000;
        frame_active_r <= 1'b0;
        crc_dis_r <= 1'b0;
        irq_pend_r <= 1'b0;
        setup_seen_r <= 1'b0;
        frame_start_r <= 1'b0;
        frame_end_r <= 1'b0;
        buf1_len_r <= 11'h000;
        buf2_len_r <= 11'h000;
        crc_append_r <= 1'b0;
        pad_len_r <= 16'h0000;
        filter_load_r <= 1'b0;
        filter_mode_r <= 2'h0;
        set_done <= 1'b0;
        set_setup <= 1'b0;
        set_err <= 1'b0;
    end else begin
        frame_start_r <= 1'b0;
        frame_end_r <= 1'b0;
        filter_load_r <= 1'b0;
        set_setup <= 1'b0;
        set_err <= 1'b0;
        set_done <= frame_sent && irq_pend_r; // [RQ1]
        if (frame_sent)
            irq_pend_r <= 1'b0;
        if (wr_fire && aw_addr_r == `TXDCW_OFF_DADDR)
            desc_addr_r <= (w_data_r & wmask) | (desc_addr_r & ~wmask);
        if (decode_go_r) begin
            desc_addr_r <= next_addr;
            next_desc_addr_r <= next_addr; // [RQ9] [RQ10] [RQ11]
            buf1_len_r <= first_buffer_byte_count; // [RQ17]
            buf2_len_r <= buf2_eff; // [RQ15] [RQ16]
            if (setup_frame_flag) begin
                // Table load only, no frame sent
                setup_seen_r <= 1'b1; // [RQ6]
                filter_load_r <= 1'b1;
                filter_mode_r <= {filter_type_high,
                                  filter_type_low}; // [RQ5] [RQ18]
                set_setup <= 1'b1;
                if (completion_irq_flag)
                    irq_pend_r <= 1'b1; // [RQ2]
            end else if (!in_frame) begin
                set_err <= 1'b1;
            end else begin
                setup_seen_r <= 1'b0;
                frame_len_r <= total_len;
                if (first_segment_flag) begin
                    frame_start_r <= 1'b1; // [RQ4]
                    frame_active_r <= 1'b1;
                    crc_dis_r <= crc_append_disable; // [RQ8]
                end
                if (last_segment_flag) begin
                    frame_end_r <= 1'b1; // [RQ3]
                    frame_active_r <= 1'b0;
                    if (completion_irq_flag)
                        irq_pend_r <= 1'b1; // [RQ1] [RQ2]
                    crc_append_r <= pad_on ||
                        !(first_segment_flag ? crc_append_disable :
                          crc_dis_r); // [RQ7] [RQ14]
                    if (pad_on && total_len <
                        (`TXDCW_MIN_FRAME - `TXDCW_CRC_BYTES))
                        pad_len_r <= `TXDCW_MIN_FRAME -
                            `TXDCW_CRC_BYTES - total_len; // [RQ13]
                    else
                        pad_len_r <= 16'h0000; // [RQ12]
                end
            end
        end
    end
end

// ------------------------------------------------------------
// Interrupt status and output
// ------------------------------------------------------------
wire [`TXDCW_NIRQ-1:0] irq_set;

assign irq_set = {set_err, set_setup, set_done};

genvar gi;
generate
    for (gi = 0; gi < `TXDCW_NIRQ; gi = gi + 1) begin : g_irq
        txdcw_stick u_stick (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(irq_set[gi]),
            .clr(rd_clr_r),
            .q_r(irq_stat[gi])
        );
    end
endgenerate

always @(posedge aclk) begin
    if (!aresetn)
        irq_r <= 1'b0;
    else
        irq_r <= |(irq_stat & irq_mask_r);
end

endmodule

// ===== rtl/txdcw_map.vh
`ifndef TXDCW_MAP_VH
`define TXDCW_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TXDCW_OFF_CTRL 8'h00
`define TXDCW_OFF_ADDR2 8'h04
`define TXDCW_OFF_BASE 8'h08
`define TXDCW_OFF_DADDR 8'h0C
`define TXDCW_OFF_DSTAT 8'h10
`define TXDCW_OFF_FLEN 8'h14
`define TXDCW_OFF_ISTAT 8'h18
`define TXDCW_OFF_IMASK 8'h1C

// ------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------
`define TXDCW_B_IRQ 31
`define TXDCW_B_LAST 30
`define TXDCW_B_FIRST 29
`define TXDCW_B_FTH 28
`define TXDCW_B_SETUP 27
`define TXDCW_B_CRCDIS 26
`define TXDCW_B_EOR 25
`define TXDCW_B_CHAIN 24
`define TXDCW_B_PADDIS 23
`define TXDCW_B_FTL 22
`define TXDCW_B2_HI 21
`define TXDCW_B2_LO 11
`define TXDCW_B1_HI 10
`define TXDCW_B1_LO 0

// ------------------------------------------------------------
// Interrupt status bits
// ------------------------------------------------------------
`define TXDCW_I_TXDONE 0
`define TXDCW_I_SETUP 1
`define TXDCW_I_SEQERR 2
`define TXDCW_NIRQ 3

// ------------------------------------------------------------
// Sizes, reset values and responses
// ------------------------------------------------------------
`define TXDCW_DESC_BYTES 32'h00000010
`define TXDCW_MIN_FRAME 16'h0040
`define TXDCW_CRC_BYTES 16'h0004
`define TXDCW_RST_WORD 32'h00000000
`define TXDCW_RESP_OKAY 2'h0
`define TXDCW_RESP_SLVERR 2'h2

`endif

// ===== rtl/txdcw_stick.v
module txdcw_stick (
    input wire aclk,
    input wire aresetn,
    input wire set,
    input wire clr,
    output reg q_r
);

// ------------------------------------------------------------
// Sticky flag, set beats clear
// ------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn)
        q_r <= 1'b0;
    else if (set)
        q_r <= 1'b1;
    else if (clr)
        q_r <= 1'b0;
end

endmodule

// ===== rtl/txdcw_nextaddr.v
module txdcw_nextaddr #(
    parameter AW = 32
) (
    input wire eor,
    input wire chain,
    input wire [AW-1:0] list_base,
    input wire [AW-1:0] addr2,
    input wire [AW-1:0] cur,
    input wire [AW-1:0] stride,
    output reg [AW-1:0] nxt
);

// ------------------------------------------------------------
// Next descriptor address selection
// ------------------------------------------------------------
always @* begin
    if (eor)
        nxt = list_base; // [RQ9] [RQ11]
    else if (chain)
        nxt = addr2; // [RQ10]
    else
        nxt = cur + stride;
end

endmodule

// ===== sim/txdcw_checker.sv
module txdcw_checker (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire frame_sent,
    input wire frame_start_r,
    input wire frame_end_r,
    input wire [10:0] buf1_len_r,
    input wire [10:0] buf2_len_r,
    input wire filter_load_r,
    input wire [1:0] filter_mode_r,
    input wire [31:0] next_desc_addr_r,
    input wire irq_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Shadow of software writes
    // ----------------------------------------
    wire wr_ok = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && s_axi_wstrb == 4'hF;
    wire ctrl_wr = wr_ok && s_axi_awaddr[7:2] == 6'h00;
    wire [31:0] w = s_axi_wdata;
    reg [31:0] word_r;
    reg [31:0] base_r;
    reg [31:0] addr2_r;
    reg pend_r;
    reg mask0_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            pend_r <= 1'h0;
            mask0_r <= 1'h0;
        end else begin
            if (ctrl_wr && w[31] && (w[30] || w[27]))
                pend_r <= 1'h1;
            else if (frame_sent)
                pend_r <= 1'h0;
            if (wr_ok && s_axi_awaddr[7:2] == 6'h07)
                mask0_r <= w[0];
        end
    end
    always @(posedge aclk) begin
        if (ctrl_wr)
            word_r <= w;
        if (wr_ok && s_axi_awaddr[7:2] == 6'h02)
            base_r <= w;
        if (wr_ok && s_axi_awaddr[7:2] == 6'h01)
            addr2_r <= w;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_ctrl;
        ctrl_wr;
    endsequence
    sequence s_settled;
        s_ctrl ##6 1'h1;
    endsequence
    chk_first_opens: assert property (
        ctrl_wr && w[29] && !w[27] |-> ##[1:6] frame_start_r)
        else $error("first segment did not open a frame");
    chk_first_quiet: assert property (
        ctrl_wr && !w[29] |-> ##1 !frame_start_r [*6])
        else $error("frame opened without first segment");
    chk_last_closes: assert property (
        ctrl_wr && w[30] && !w[27] |-> ##[1:6] frame_end_r)
        else $error("last segment did not close the frame");
    chk_setup_load: assert property (
        ctrl_wr && w[27] |-> ##[1:6] filter_load_r)
        else $error("setup descriptor did not load filter");
    chk_filter_mode: assert property (
        $rose(filter_load_r) |-> filter_mode_r == {word_r[28], word_r[22]})
        else $error("filter mode differs from control word");
    chk_buf1_len: assert property (
        s_settled |-> buf1_len_r == word_r[10:0])
        else $error("buffer one length wrong");
    chk_buf2_chain: assert property (
        s_settled |-> buf2_len_r == (word_r[24] ? 11'h0 : word_r[21:11]))
        else $error("buffer two length wrong");
    chk_next_addr: assert property (
        s_settled |-> (word_r[25] ? next_desc_addr_r == base_r :
            (!word_r[24] || next_desc_addr_r == addr2_r)))
        else $error("next descriptor address wrong");
    chk_done_irq: assert property (
        frame_sent && pend_r && mask0_r |-> ##[2:4] irq_r)
        else $error("completion did not raise interrupt");
endmodule

bind txdcw_top txdcw_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .frame_sent(frame_sent), .frame_start_r(frame_start_r),
    .frame_end_r(frame_end_r), .buf1_len_r(buf1_len_r),
    .buf2_len_r(buf2_len_r), .filter_load_r(filter_load_r),
    .filter_mode_r(filter_mode_r), .next_desc_addr_r(next_desc_addr_r),
    .irq_r(irq_r)
);

// ===== sim/txdcw_host_mem.sv
module txdcw_host_mem;
    timeunit 1ns;
    timeprecision 1ps;
    // Driver assembles every field before handing the word over
    function automatic logic [31:0] pack(input logic irq, last, first,
            input logic [1:0] ft, input logic setup, crcdis, eor, chain,
            paddis, input logic [10:0] b2, b1);
        return {irq, last, first, ft[1], setup, crcdis, eor, chain, paddis,
            ft[0], b2, b1};
    endfunction
endmodule

// ===== sim/test_tx_descriptor_control_word_decode.sv
module test_tx_descriptor_control_word_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, frame_sent = 1'h0;
    logic [31:0] wdata = 32'h0;
    wire awready, wready, bvalid, arready, rvalid, fs_p, fe_p, fl_p;
    wire crc, irq;
    wire [1:0] bresp, rresp, fmode;
    wire [31:0] rdata, nda;
    wire [10:0] b1l, b2l;
    wire [15:0] padl;
    int fail_count = 0, n_tests = 0, cyc = 0, flen = 0;
    logic seen_fs, seen_fe, seen_fl, crcdis, pend;
    logic [31:0] base, addr2, cur, rd;
    logic [2:0] st, mask;
    logic [1:0] rs;
    logic in_frm = 1'h0;

    always #4 aclk = ~aclk;

    txdcw_host_mem host ();
    txdcw_top dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .frame_sent(frame_sent), .frame_start_r(fs_p), .frame_end_r(fe_p),
        .buf1_len_r(b1l), .buf2_len_r(b2l), .crc_append_r(crc),
        .pad_len_r(padl), .filter_load_r(fl_p), .filter_mode_r(fmode),
        .next_desc_addr_r(nda), .irq_r(irq)
    );

    // ----------------------------------------
    // Pulse capture and hang guard
    // ----------------------------------------
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (fs_p) seen_fs <= 1'h1;
        if (fe_p) seen_fe <= 1'h1;
        if (fl_p) seen_fl <= 1'h1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (e !== g) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ----------------------------------------
    // Register bus master
    // ----------------------------------------
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
            output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!(bvalid && bready));
        r = bresp;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
    endtask

    // ----------------------------------------
    // Reference model and comparisons
    // ----------------------------------------
    task automatic desc(input logic [31:0] w);
        logic [31:0] nx;
        int b2, pad;
        nx = w[25] ? base : (w[24] ? addr2 : cur + 32'h10);
        b2 = w[24] ? 0 : w[21:11];
        if (w[29]) begin
            flen = 0;
            crcdis = w[26];
        end
        if (!w[27]) flen += w[10:0] + b2;
        if (w[31] && (w[30] || w[27])) pend = 1'h1;
        if (w[27]) st[1] = 1'h1;
        // Non-first segment with no open frame is a sequence error
        if (!w[27] && !w[29] && !in_frm) st[2] = 1'h1;
        if (!w[27]) in_frm = (w[29] || in_frm) && !w[30];
        seen_fs = 1'h0;
        seen_fe = 1'h0;
        seen_fl = 1'h0;
        axw(8'h00, w, rs);
        repeat (6) @(posedge aclk);
        chk("ctrl_resp", 0, rs);
        chk("buf1_len", w[10:0], b1l);
        chk("buf2_len", b2, b2l);
        chk("next_addr", nx, nda);
        cur = nx;
        chk("frame_start", w[29] && !w[27], seen_fs);
        chk("frame_end", w[30] && !w[27], seen_fe);
        chk("filter_load", w[27], seen_fl);
        if (w[27]) chk("filter_mode", {w[28], w[22]}, fmode);
        if (w[30] && !w[27]) begin
            pad = (!w[23] && flen < 60) ? 60 - flen : 0;
            chk("pad_len", pad, padl);
            chk("crc", !crcdis || (!w[23] && flen < 64), crc);
        end
    endtask

    task automatic sent(input logic [2:0] m);
        axw(8'h1C, {29'h0, m}, rs);
        mask = m;
        frame_sent <= 1'h1;
        @(posedge aclk);
        frame_sent <= 1'h0;
        if (pend) st[0] = 1'h1;
        pend = 1'h0;
        repeat (4) @(posedge aclk);
        chk("irq", |(st & mask), irq);
        axr(8'h18, rd, rs);
        chk("irq_status", st, rd[2:0]);
        st = 3'h0;
        repeat (2) @(posedge aclk);
        chk("irq_cleared", 0, irq);
    endtask

    initial begin
        logic [31:0] w, r, q;
        int nseg;
        void'($urandom(32'h7C554F5E));
        st = 3'h0;
        pend = 1'h0;
        crcdis = 1'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        base = 32'h00001000;
        addr2 = 32'h00002400;
        cur = 32'h00003000;
        axw(8'h08, base, rs);
        axw(8'h04, addr2, rs);
        axw(8'h0C, cur, rs);
        axr(8'h1C, rd, rs);
        chk("mask_reset", 0, rd);
        axw(8'h20, 32'h1, rs);
        chk("wr_unmapped", 2, rs);
        axr(8'h24, rd, rs);
        chk("rd_unmapped", 32'h2, {rd[29:0], rs});
        for (int i = 0; i < 8; i++) begin
            w = host.pack(1'h1, 1'h1, 1'h1, 2'h0, 1'h0, i[1], 1'h0, 1'h0,
                i[0], 11'h0, 11'h39 + 11'(i));
            desc(w);
            sent(3'h1);
        end
        for (int f = 0; f < 16; f++) begin
            nseg = $urandom_range(1, 3);
            for (int s = 0; s < nseg; s++) begin
                r = $urandom;
                q = $urandom;
                w = host.pack(r[0], s == nseg - 1, s == 0, 2'h0, 1'h0, r[1],
                    r[2], r[3], r[4], r[9] ? q[26:16] : {5'h0, q[21:16]},
                    r[8] ? q[10:0] : {5'h0, q[5:0]});
                desc(w);
            end
            sent(r[5] ? 3'h3 : 3'h0);
        end
        // Orphan middle segment, completion flag must be ignored
        w = host.pack(1'h1, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0,
            11'h0, 11'h10);
        desc(w);
        sent(3'h4);
        for (int m = 0; m < 4; m++) begin
            r = $urandom;
            w = host.pack(r[0], 1'h0, 1'h0, m[1:0], 1'h1, 1'h0, r[2], r[3],
                1'h0, r[26:16], r[10:0]);
            desc(w);
            sent(3'h3);
        end
        end_of_test();
    end
endmodule
